// ==== logic/sp_uart.sv ====
// serial port top: control registers, baud ticks, shift mode
module sp_uart
   import sp_pkg::*;
(
   input  wire logic        mclk_in,               // core clock
   input  wire logic        rst_n_in,              // sync reset
   input  wire sp_sfr_req_s sfr_req_in,            // register access
   output logic [7:0]       sfr_rdata_out,         // read data
   input  wire logic        baud_double_in,        // rate double
   input  wire logic        t2_rx_clock_select_in, // rx from t2
   input  wire logic        t2_tx_clock_select_in, // tx from t2
   input  wire logic        t1_ovf_in,             // timer 1 pulse
   input  wire logic        t2_ovf_in,             // timer 2 pulse
   input  wire logic        rxd_in,                // rxd pin level
   output logic             rxd_out,               // rxd drive
   output logic             rxd_oe_out,            // rxd enable
   output logic             txd_out,               // txd pin
   output logic             t2_flag_inhibit_out,   // block t2 flag
   output logic             serial_irq_out         // serial request
);
   typedef enum logic [2:0] {
      M0_IDLE = 3'b001,
      M0_TX   = 3'b010,
      M0_RX   = 3'b100
   } sp_m0_st_e;

   sp_ctrl_s    ctrl_ff;
   logic [7:0]  rxbuf_ff;
   logic        rxd_meta_ff;
   logic        rxd_s_ff;
   logic [1:0]  mode;
   logic        async;
   logic        wr_ctrl;
   logic        wr_data;

   logic [1:0]  m2_div_ff;
   logic        m2_tick;
   logic        t1_half_ff;
   logic        t1_tick;
   logic [1:0]  chan_tick;

   logic        tx_txd;
   logic        tx_stop;
   logic        tx_busy;
   logic        rx_done;
   sp_rx_word_s rx_word;

   sp_m0_st_e   m0_st_ff;
   logic [3:0]  m0_div_ff;
   logic [2:0]  m0_cnt_ff;
   logic [7:0]  m0_sh_ff;
   logic        m0_go_tx;
   logic        m0_go_rx;
   logic        m0_end;
   logic        m0_bit_end;
   logic [7:0]  m0_rx_word;

   logic        ti_set;
   logic        rx_load;

   // mode bits decode the frame format and the baud source
   assign mode  = {ctrl_ff.mode_hi, ctrl_ff.mode_lo};
   assign async = mode != SP_MODE_SHIFT;

   assign wr_ctrl = sfr_req_in.wr && sfr_req_in.addr == SP_ADDR_CTRL;
   assign wr_data = sfr_req_in.wr && sfr_req_in.addr == SP_ADDR_DATA;

   // pin synchroniser; only the second stage is used
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rxd_meta_ff <= 1'b1;
         rxd_s_ff    <= 1'b1;
      end else begin
         rxd_meta_ff <= rxd_in;
         rxd_s_ff    <= rxd_meta_ff;
      end
   end

   // fixed rate: 16 ticks per bit, so 4 or 2 core clocks a tick
   assign m2_tick = m2_div_ff ==
                    (baud_double_in ? SP_M2_LAST_FAST : SP_M2_LAST_SLOW);

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) m2_div_ff <= 2'h0;
      else if (m2_tick) m2_div_ff <= 2'h0;
      else m2_div_ff <= m2_div_ff + 2'h1;
   end

   // timer 1 overflows halved unless the rate is doubled
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) t1_half_ff <= 1'b0;
      else if (t1_ovf_in) t1_half_ff <= !t1_half_ff;
   end

   assign t1_tick = t1_ovf_in && (baud_double_in || t1_half_ff);

   // channel 0 feeds the transmitter, channel 1 the receiver
   for (genvar ch = 0; ch < 2; ch++) begin : g_tick
      logic use_t2;
      assign use_t2 = (ch == 0) ? t2_tx_clock_select_in
                                : t2_rx_clock_select_in;
      assign chan_tick[ch] = (mode == SP_MODE_FIX9) ? m2_tick
                           : (use_t2 ? t2_ovf_in : t1_tick);
   end

   sp_tx u_tx (
      .mclk_in  (mclk_in),
      .rst_n_in (rst_n_in),
      .tick_in  (chan_tick[0]),
      .start_in (wr_data && async),
      .nine_in  (ctrl_ff.mode_hi),
      .frame_in ({ctrl_ff.tx_ninth_bit, sfr_req_in.wdata}),
      .txd_out  (tx_txd),
      .stop_out (tx_stop),
      .busy_out (tx_busy)
   );

   sp_rx u_rx (
      .mclk_in  (mclk_in),
      .rst_n_in (rst_n_in),
      .tick_in  (chan_tick[1]),
      .en_in    (ctrl_ff.rx_enable && async),
      .nine_in  (ctrl_ff.mode_hi),
      .rxd_in   (rxd_s_ff),
      .done_out (rx_done),
      .word_out (rx_word)
   );

   // shift mode: one bit every 12 core clocks, 8 bits lsb first.
   // a data write while a shift is running is ignored, which keeps
   // the external shift clock free of short pulses.
   assign m0_go_tx = wr_data && !async && m0_st_ff == M0_IDLE;
   assign m0_go_rx = !async && m0_st_ff == M0_IDLE && !m0_go_tx &&
                     ctrl_ff.rx_enable &&
                     !ctrl_ff.rx_done_flag;
   assign m0_bit_end = m0_st_ff != M0_IDLE &&
                       m0_div_ff == SP_M0_LAST;
   assign m0_end = m0_bit_end && m0_cnt_ff == SP_M0_BIT_LAST;
   assign m0_rx_word = {rxd_s_ff, m0_sh_ff[7:1]};

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         m0_st_ff  <= M0_IDLE;
         m0_div_ff <= 4'h0;
         m0_cnt_ff <= 3'h0;
      end else if (m0_go_tx || m0_go_rx) begin
         m0_st_ff  <= m0_go_tx ? M0_TX : M0_RX;
         m0_div_ff <= 4'h0;
         m0_cnt_ff <= 3'h0;
      end else if (m0_bit_end) begin
         m0_div_ff <= 4'h0;
         if (m0_end) m0_st_ff <= M0_IDLE;
         else m0_cnt_ff <= m0_cnt_ff + 3'h1;
      end else if (m0_st_ff != M0_IDLE) begin
         m0_div_ff <= m0_div_ff + 4'h1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) m0_sh_ff <= 8'h00;
      else if (m0_go_tx) m0_sh_ff <= sfr_req_in.wdata;
      else if (m0_bit_end && m0_st_ff == M0_TX)
         m0_sh_ff <= {1'b1, m0_sh_ff[7:1]};
      else if (m0_bit_end && m0_st_ff == M0_RX)
         m0_sh_ff <= m0_rx_word;
   end

   // shift clock low for the first half of each bit, high at rest
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         txd_out    <= 1'b1;
         rxd_out    <= 1'b1;
         rxd_oe_out <= 1'b0;
      end else begin
         txd_out    <= async ? tx_txd
                     : !(m0_st_ff != M0_IDLE &&
                         m0_div_ff < SP_M0_HALF);
         rxd_out    <= m0_sh_ff[0];
         rxd_oe_out <= m0_st_ff == M0_TX;
      end
   end

   // events that raise the done flags
   assign ti_set  = tx_stop || (m0_end && m0_st_ff == M0_TX);
   // a frame that ends while the flag is still set is lost
   assign rx_load = !ctrl_ff.rx_done_flag &&
                    ((async && rx_done &&
                      (!ctrl_ff.multiproc_enable ||
                       rx_word.bit9)) ||
                     (m0_end && m0_st_ff == M0_RX));

   // hardware sets are written last so they win over a clear
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ctrl_ff <= SP_CTRL_RESET;
      end else begin
         if (wr_ctrl) ctrl_ff <= sfr_req_in.wdata;
         if (ti_set) ctrl_ff.tx_done_flag <= 1'b1;
         if (rx_load) begin
            ctrl_ff.rx_done_flag <= 1'b1;
            if (async) ctrl_ff.rx_ninth_bit <= rx_word.bit9;
         end
      end
   end

   // receive buffer is separate from both shift registers
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) rxbuf_ff <= SP_RXBUF_RESET;
      else if (rx_load)
         rxbuf_ff <= async ? rx_word.data : m0_rx_word;
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_req_in.rd) begin
         unique case (sfr_req_in.addr)
            SP_ADDR_CTRL: sfr_rdata_out <= ctrl_ff;
            SP_ADDR_DATA: sfr_rdata_out <= rxbuf_ff;
            default:      sfr_rdata_out <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         t2_flag_inhibit_out <= 1'b0;
         serial_irq_out      <= 1'b0;
      end else begin
         t2_flag_inhibit_out <= t2_rx_clock_select_in ||
                                t2_tx_clock_select_in;
         serial_irq_out      <= ctrl_ff.tx_done_flag ||
                                ctrl_ff.rx_done_flag;
      end
   end

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_ti_on_stop: assert property (
      tx_stop |=> ctrl_ff.tx_done_flag)
      else $error("tx done flag missed stop bit start");

   a_ri_full_drop: assert property (
      rx_done && ctrl_ff.rx_done_flag |=> $stable(rxbuf_ff))
      else $error("receive buffer changed while flag set");

   a_mpe_mode1: assert property (
      rx_done && mode == SP_MODE_VAR8 && ctrl_ff.multiproc_enable &&
      !rx_word.bit9 && !ctrl_ff.rx_done_flag && !wr_ctrl
      |=> !ctrl_ff.rx_done_flag)
      else $error("mode 1 frame with bad stop accepted");

   a_mpe_ninth: assert property (
      rx_done && ctrl_ff.mode_hi && ctrl_ff.multiproc_enable &&
      !rx_word.bit9 && !ctrl_ff.rx_done_flag && !wr_ctrl
      |=> !ctrl_ff.rx_done_flag && $stable(rxbuf_ff))
      else $error("frame with ninth bit zero accepted");

   a_rx_load_word: assert property (
      rx_done && async && !ctrl_ff.rx_done_flag &&
      !ctrl_ff.multiproc_enable
      |=> ctrl_ff.rx_done_flag && rxbuf_ff == $past(rx_word.data) &&
          ctrl_ff.rx_ninth_bit == $past(rx_word.bit9))
      else $error("received word not loaded");

   a_m0_length: assert property (
      $rose(m0_st_ff != M0_IDLE)
      |-> ##95 (m0_st_ff != M0_IDLE) ##1 (m0_st_ff == M0_IDLE))
      else $error("shift mode transfer not 96 clocks");

   a_rx_off_hold: assert property (
      m0_st_ff == M0_IDLE && !ctrl_ff.rx_enable |=> m0_st_ff != M0_RX)
      else $error("shift receive started while disabled");

   a_m0_rx_gate: assert property (
      m0_st_ff == M0_IDLE && ctrl_ff.rx_done_flag |=> m0_st_ff != M0_RX)
      else $error("shift receive started with flag set");

   a_m0_pin_dir: assert property (
      m0_st_ff == M0_RX ##1 m0_st_ff == M0_RX |-> !rxd_oe_out)
      else $error("rxd driven during shift receive");

   a_tx_idle_high: assert property (
      async && !tx_busy ##1 async |-> txd_out)
      else $error("txd not high between frames");

   a_data_write_sep: assert property (
      wr_data && !rx_load |=> $stable(rxbuf_ff))
      else $error("data write altered receive buffer");

   a_async_tx_start: assert property (
      wr_data && async |=> tx_busy)
      else $error("data write did not start async frame");

   a_m0_tx_start: assert property (
      wr_data && !async && m0_st_ff == M0_IDLE |=> m0_st_ff == M0_TX)
      else $error("data write did not start shift transmit");

   a_rx_flag_set: assert property (
      rx_load |=> ctrl_ff.rx_done_flag)
      else $error("accepted frame did not raise rx done flag");

   a_irq_follows: assert property (
      serial_irq_out ==
      $past(ctrl_ff.tx_done_flag || ctrl_ff.rx_done_flag))
      else $error("serial request does not follow done flags");

   a_t2_inhibit: assert property (
      t2_flag_inhibit_out ==
      $past(t2_rx_clock_select_in || t2_tx_clock_select_in))
      else $error("timer 2 flag inhibit wrong");
endmodule // sp_uart

// ==== logic/sp_pkg.sv ====
// package: serial port constants, carrier types and operation summary
// Summary of operation
// - received byte waits while next shifts in
// - data address: write to tx, read rx
// - mode bits select shift, 8-bit, 9-bit fixed/variable
// - mode 1 multiproc: need valid stop bit
// - modes 2/3 multiproc: drop frame if ninth zero
// - no reception starts while receive enable clear
// - tx ninth bit sent as ninth bit
// - rx ninth bit captures ninth or stop
// - tx done at 8th bit end / stop start
// - rx done at 8th bit end / mid stop
// - mode 0: data on rxd, clock on txd
// - mode 0 receive starts when enabled, rx-done clear
// - mode 1 frame: start, 8 lsb-first, stop
// - data write starts tx; mode 1 stop bit
// - async receive starts on falling rxd edge
// - load only if rx-done clear and gate met
// - mode 2: 11 bits, clock/64 or /32
// - mode 2 tx starts at next baud tick
// - modes 1/3 baud from timer overflows
// - mode 0 shift every 12 core clocks
// - timer 2 overflow flag inhibited in baud use
// - timer 2 selects route rx/tx baud clocks
// - bit is 16 overflows, timer 1 halved
package sp_pkg;
   localparam logic [7:0] SP_ADDR_CTRL    = 8'h98;
   localparam logic [7:0] SP_ADDR_DATA    = 8'h99;
   localparam logic [7:0] SP_CTRL_RESET   = 8'h00;
   localparam logic [7:0] SP_RXBUF_RESET  = 8'h00;
   localparam logic [1:0] SP_MODE_SHIFT   = 2'h0;
   localparam logic [1:0] SP_MODE_VAR8    = 2'h1;
   localparam logic [1:0] SP_MODE_FIX9    = 2'h2;
   localparam logic [1:0] SP_MODE_VAR9    = 2'h3;
   localparam logic [3:0] SP_M0_LAST      = 4'hb;
   localparam logic [3:0] SP_M0_HALF      = 4'h6;
   localparam logic [2:0] SP_M0_BIT_LAST  = 3'h7;
   localparam logic [1:0] SP_M2_LAST_SLOW = 2'h3;
   localparam logic [1:0] SP_M2_LAST_FAST = 2'h1;
   localparam logic [3:0] SP_OVS_MID      = 4'h7;
   localparam logic [3:0] SP_OVS_LAST     = 4'hf;
   localparam logic [3:0] SP_TX_STOP8     = 4'h9;
   localparam logic [3:0] SP_TX_STOP9     = 4'ha;
   localparam logic [3:0] SP_RX_LAST8     = 4'h7;
   localparam logic [3:0] SP_RX_LAST9     = 4'h8;

   typedef struct packed {
      logic mode_hi;
      logic mode_lo;
      logic multiproc_enable;
      logic rx_enable;
      logic tx_ninth_bit;
      logic rx_ninth_bit;
      logic tx_done_flag;
      logic rx_done_flag;
   } sp_ctrl_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sp_sfr_req_s;

   typedef struct packed {
      logic [7:0] data;
      logic       bit9;
   } sp_rx_word_s;
endpackage

// ==== logic/sp_tx.sv ====
// asynchronous frame transmitter for modes 1 to 3
module sp_tx
   import sp_pkg::*;
(
   input  wire logic       mclk_in,  // core clock
   input  wire logic       rst_n_in, // sync reset, active low
   input  wire logic       tick_in,  // 16x baud tick
   input  wire logic       start_in, // load frame and send
   input  wire logic       nine_in,  // 11-bit frame
   input  wire logic [8:0] frame_in, // ninth bit and data
   output logic            txd_out,  // serial line
   output logic            stop_out, // stop bit begins
   output logic            busy_out  // frame in flight
);
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_WAIT = 3'b010,
      TX_RUN  = 3'b100
   } sp_tx_st_e;

   sp_tx_st_e   st_ff;
   logic [10:0] sh_ff;
   logic [3:0]  tcnt_ff;
   logic [3:0]  bit_ff;
   logic [3:0]  last_ff;
   logic        bit_end;

   assign bit_end = tick_in && st_ff == TX_RUN && tcnt_ff == SP_OVS_LAST;
   assign busy_out = st_ff != TX_IDLE;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         st_ff   <= TX_IDLE;
         tcnt_ff <= 4'h0;
         bit_ff  <= 4'h0;
      end else if (start_in) begin
         st_ff   <= TX_WAIT;
         tcnt_ff <= 4'h0;
         bit_ff  <= 4'h0;
      end else if (tick_in) begin
         unique case (st_ff)
            TX_IDLE: ;
            TX_WAIT: st_ff <= TX_RUN;
            TX_RUN: begin
               tcnt_ff <= tcnt_ff + 4'h1;
               if (tcnt_ff == SP_OVS_LAST) begin
                  if (bit_ff == last_ff) st_ff <= TX_IDLE;
                  else bit_ff <= bit_ff + 4'h1;
               end
            end
         endcase
      end
   end

   // slot 9 is the stop bit in mode 1 and the ninth bit otherwise
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sh_ff   <= 11'h7ff;
         last_ff <= SP_TX_STOP8;
      end else if (start_in) begin
         sh_ff   <= {1'b1, nine_in ? frame_in[8] : 1'b1,
                     frame_in[7:0], 1'b0};
         last_ff <= nine_in ? SP_TX_STOP9 : SP_TX_STOP8;
      end else if (bit_end) begin
         sh_ff <= {1'b1, sh_ff[10:1]};
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         txd_out  <= 1'b1;
         stop_out <= 1'b0;
      end else begin
         txd_out  <= (st_ff == TX_RUN) ? sh_ff[0] : 1'b1;
         stop_out <= bit_end && (bit_ff + 4'h1 == last_ff);
      end
   end
endmodule // sp_tx

// ==== logic/sp_rx.sv ====
// asynchronous frame receiver for modes 1 to 3
module sp_rx
   import sp_pkg::*;
(
   input  wire logic  mclk_in,  // core clock
   input  wire logic  rst_n_in, // sync reset, active low
   input  wire logic  tick_in,  // 16x baud tick
   input  wire logic  en_in,    // reception allowed
   input  wire logic  nine_in,  // 11-bit frame
   input  wire logic  rxd_in,   // synchronised line
   output logic       done_out, // mid stop bit pulse
   output sp_rx_word_s word_out // received byte and bit 9
);
   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } sp_rx_st_e;

   sp_rx_st_e  st_ff;
   logic       prev_ff;
   logic [3:0] tcnt_ff;
   logic [3:0] cnt_ff;
   logic [8:0] sh_ff;
   logic       mid;

   assign mid = tick_in && tcnt_ff == SP_OVS_MID;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) prev_ff <= 1'b1;
      else prev_ff <= rxd_in;
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         st_ff   <= RX_IDLE;
         tcnt_ff <= 4'h0;
         cnt_ff  <= 4'h0;
         sh_ff   <= 9'h000;
      end else begin
         if (tick_in) tcnt_ff <= tcnt_ff + 4'h1;
         unique case (st_ff)
            RX_IDLE: if (en_in && prev_ff && !rxd_in) begin
               st_ff   <= RX_START;
               tcnt_ff <= 4'h0;
               cnt_ff  <= 4'h0;
            end
            // a start bit gone high by mid-bit was a glitch
            RX_START: if (mid) st_ff <= rxd_in ? RX_IDLE : RX_DATA;
            RX_DATA: if (mid) begin
               sh_ff  <= {rxd_in, sh_ff[8:1]};
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == (nine_in ? SP_RX_LAST9 : SP_RX_LAST8))
                  st_ff <= RX_STOP;
            end
            RX_STOP: if (mid) st_ff <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         done_out <= 1'b0;
         word_out <= '0;
      end else begin
         done_out <= st_ff == RX_STOP && mid;
         if (st_ff == RX_STOP && mid) begin
            word_out.data <= nine_in ? sh_ff[7:0] : sh_ff[8:1];
            word_out.bit9 <= nine_in ? sh_ff[8] : rxd_in;
         end
      end
   end
endmodule // sp_rx

// ==== verification/sp_peer.sv ====
// remote serial peer: async frames both ways and a mode 0 shift device
module sp_peer (
   input  wire logic mclk_in, // core clock
   input  wire logic txd_in,  // device txd pin
   input  wire logic line_in, // resolved rxd line
   output logic      rxd_out  // peer drive, pulled up when idle
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       m0_on     = 1'b0;
   logic [7:0] m0_src    = 8'h00;
   logic [7:0] m0_got    = 8'h00;
   logic [2:0] m0_idx    = 3'h0;
   logic       txd_q     = 1'b1;
   int         m0_rises  = 0;
   int         m0_gap    = 0;
   int         cyc       = 0;
   int         last_rise = 0;

   initial rxd_out = 1'b1;

   // line changes by non-blocking update on the rising edge, as a flop would
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      txd_q <= txd_in;
      if (m0_on && txd_q && !txd_in) begin
         rxd_out <= m0_src[m0_idx];
         m0_idx <= m0_idx + 3'h1;
      end
      if (m0_on && !txd_q && txd_in) begin
         m0_got <= {line_in, m0_got[7:1]};
         m0_rises <= m0_rises + 1;
         m0_gap <= cyc - last_rise;
         last_rise <= cyc;
      end
   end

   task automatic m0_arm(input logic [7:0] src);
      m0_src = src;
      m0_idx = 3'h0;
      m0_rises = 0;
      m0_on = 1'b1;
   endtask

   // start 0, data lsb first, optional ninth, stop; line left high
   task automatic send(input logic [8:0] f, input logic nine, stp,
                       input int bc);
      logic [10:0] b;
      int          n;
      b = {stp, f, 1'b0};
      n = nine ? 11 : 10;
      if (!nine) b[9] = stp;
      for (int i = 0; i < n; i++) begin
         rxd_out <= b[i];
         repeat (bc) @(posedge mclk_in);
      end
      rxd_out <= 1'b1;
   endtask

   // waits for a start bit, then samples every bit at its middle
   task automatic recv(input logic nine, input int bc,
                       output logic [10:0] b);
      int w;
      int n;
      b = '1;
      w = 0;
      n = nine ? 11 : 10;
      while (txd_in !== 1'b0 && w < 3000) begin
         @(posedge mclk_in);
         #1 w++;
      end
      repeat (bc / 2) @(posedge mclk_in);
      for (int i = 0; i < n; i++) begin
         #1 b[i] = txd_in; // sampled off the edge, where txd has settled
         if (i < n - 1) repeat (bc) @(posedge mclk_in);
      end
   endtask
endmodule // sp_peer

// ==== verification/sp_uart_tb_top.sv ====
// self-checking testbench for the serial port top
module sp_uart_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sp_pkg::*;

   localparam logic [1:0] TX_MODE [5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h1};
   localparam logic [4:0] TX_DBL = 5'b10100;
   localparam logic [4:0] TX_SEL = 5'b01000;
   localparam logic [7:0] RX_CTRL [7] =
      '{8'h50, 8'h70, 8'hb0, 8'hf0, 8'h40, 8'h91, 8'h90};
   localparam logic [6:0] RX_B9  = 7'b0111001;
   localparam logic [6:0] RX_OK  = 7'b1001001;
   localparam logic [6:0] RX_SEL = 7'b0001000;
   localparam logic [6:0] RX_DBL = 7'b1000000;

   logic        clk   = 1'b0;
   logic        rst_n = 1'b0;
   sp_sfr_req_s req   = '0;
   logic        dbl   = 1'b0;
   logic        rsel  = 1'b0;
   logic        tsel  = 1'b0;
   logic        t1    = 1'b0;
   logic        t2    = 1'b0;
   logic [7:0]  rdata;
   logic        rxd_drv;
   logic        rxd_oe;
   logic        txd;
   logic        inh;
   logic        irq;
   logic        peer_rxd;
   logic [31:0] seed  = 32'h3e;
   int          err_total   = 0;
   int          checks_done = 0;
   int          cyc         = 0;
   wire logic   rxd_line    = rxd_oe ? rxd_drv : peer_rxd;

   always #2.5 clk = ~clk;

   // overflow pulse every other cycle: halved timer 1 ticks each 4 clocks
   always @(posedge clk) begin
      cyc <= cyc + 1;
      t1 <= #1 ~t1;
      t2 <= #1 ~t2;
      if (cyc == 30000) begin
         err_total++;
         print_verdict();
      end
   end

   sp_uart i_dut (
      .mclk_in               (clk),
      .rst_n_in              (rst_n),
      .sfr_req_in            (req),
      .sfr_rdata_out         (rdata),
      .baud_double_in        (dbl),
      .t2_rx_clock_select_in (rsel),
      .t2_tx_clock_select_in (tsel),
      .t1_ovf_in             (t1),
      .t2_ovf_in             (t2),
      .rxd_in                (rxd_line),
      .rxd_out               (rxd_drv),
      .rxd_oe_out            (rxd_oe),
      .txd_out               (txd),
      .t2_flag_inhibit_out   (inh),
      .serial_irq_out        (irq)
   );

   sp_peer i_peer (
      .mclk_in (clk),
      .txd_in  (txd),
      .line_in (rxd_line),
      .rxd_out (peer_rxd)
   );

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // clocks per bit: fixed rate uses the core clock, else timer ticks
   function automatic int bclk(input logic [1:0] m, input logic d, s);
      return (s && m != SP_MODE_FIX9) ? 32 : (d ? 32 : 64);
   endfunction

   task automatic chk(input string what, input logic [10:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      #1 req = '0;
   endtask

   task automatic rdchk(input logic [7:0] a, exp, input string what);
      @(posedge clk);
      #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1 req = '0;
      chk(what, 11'(rdata), 11'(exp));
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      logic [31:0] r;
      logic [10:0] f;
      logic [7:0]  c;
      logic [7:0]  last;
      int          bc;
      last = SP_RXBUF_RESET;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      rdchk(SP_ADDR_CTRL, 8'h00, "ctrl reset");
      rdchk(SP_ADDR_DATA, 8'h00, "rxbuf reset");
      rdchk(8'h42, 8'h00, "unmapped read");
      chk("txd idle", 11'(txd), 11'h1);
      chk("irq idle", 11'(irq), 11'h0);
      $display("reset test done");
      for (int i = 0; i < 5; i++) begin
         r = rnd();
         wr(SP_ADDR_CTRL, {TX_MODE[i], 2'b00, r[8], 3'b000});
         dbl = TX_DBL[i];
         tsel = TX_SEL[i];
         bc = bclk(TX_MODE[i], TX_DBL[i], TX_SEL[i]);
         fork
            wr(SP_ADDR_DATA, r[7:0]);
            i_peer.recv(TX_MODE[i][1], bc, f);
         join
         chk("tx frame", f, {1'b1, TX_MODE[i][1] ? r[8] : 1'b1,
             r[7:0], 1'b0});
         chk("tx irq", 11'(irq), 11'h1);
         chk("t2 inhibit", 11'(inh), 11'(TX_SEL[i]));
         rdchk(SP_ADDR_CTRL, {TX_MODE[i], 2'b00, r[8], 3'b010},
               "tx flag");
         repeat (bc) @(posedge clk);
      end
      tsel = 1'b0;
      $display("async transmit test done");
      for (int i = 0; i < 7; i++) begin
         r = rnd();
         c = RX_CTRL[i];
         wr(SP_ADDR_CTRL, c);
         rsel = RX_SEL[i];
         dbl = RX_DBL[i];
         bc = bclk(c[7:6], RX_DBL[i], RX_SEL[i]);
         i_peer.send({RX_B9[i], r[7:0]}, c[7], c[7] | RX_B9[i], bc);
         repeat (8) @(posedge clk);
         if (RX_OK[i]) last = r[7:0];
         if (RX_OK[i]) c = c | 8'h01 | (RX_B9[i] ? 8'h04 : 8'h00);
         rdchk(SP_ADDR_DATA, last, "rx data");
         rdchk(SP_ADDR_CTRL, c, "rx flags");
      end
      $display("async receive test done");
      wr(SP_ADDR_CTRL, 8'h00);
      r = rnd();
      i_peer.m0_arm(r[15:8]);
      wr(SP_ADDR_DATA, r[7:0]);
      repeat (100) @(posedge clk);
      chk("m0 tx data", 11'(i_peer.m0_got), 11'(r[7:0]));
      chk("m0 tx bits", 11'(i_peer.m0_rises), 11'h8);
      chk("m0 bit time", 11'(i_peer.m0_gap), 11'hc);
      rdchk(SP_ADDR_CTRL, 8'h02, "m0 tx flag");
      i_peer.m0_arm(r[15:8]);
      wr(SP_ADDR_CTRL, 8'h10);
      repeat (200) @(posedge clk);
      rdchk(SP_ADDR_DATA, r[15:8], "m0 rx data");
      rdchk(SP_ADDR_CTRL, 8'h11, "m0 rx flag");
      chk("m0 rx halts", 11'(i_peer.m0_rises), 11'h8);
      $display("shift mode test done");
      print_verdict();
   end
endmodule // sp_uart_tb_top
